/* pkg/sap_cfg.svh */
`ifndef SAP_CFG_SVH
`define SAP_CFG_SVH

// Register byte offsets
`define SAP_OFF_CFG_FIRST 8'h00
`define SAP_OFF_CFG_SECOND 8'h04
`define SAP_OFF_STATUS 8'h08
`define SAP_OFF_PERIOD 8'h0C

// config_reg_first fields
`define SAP_F_SKIP 0
`define SAP_F_SRC_SEL 1
`define SAP_F_SPDIF_ANALOG 2
`define SAP_RST_CFG_FIRST 32'h0000_0000

// config_reg_second fields
`define SAP_F_IN_FMT_LO 0
`define SAP_F_IN_BCLK_POL 3
`define SAP_F_IN_WCLK_POL 4
`define SAP_F_IN_MASTER 5
`define SAP_F_OUT_FMT_LO 8
`define SAP_F_OUT_BCLK_POL 11
`define SAP_F_OUT_WCLK_POL 12
`define SAP_F_OUT_SLAVE 13
// Input: mode 1, bit-clock pol 1, word-clock pol 0, slave.
// Output: mode 1, bit-clock pol 1, word-clock pol 0, master.
`define SAP_RST_CFG_SECOND 32'h0000_0909

// status fields
`define SAP_F_FIR_ON 0
`define SAP_F_BYPASS 1
`define SAP_F_IN_FMT_ERR 2
`define SAP_F_OUT_FMT_ERR 3
`define SAP_F_SRC_LO 4
`define SAP_F_AC_PIN 6

// Frame formats
`define SAP_SLOTS_LONG 6'd32
`define SAP_SLOTS_SHORT 6'd24
`define SAP_WIDTH_LONG 6'd24
`define SAP_WIDTH_SHORT 6'd16
`define SAP_MODE_RESERVED 3'h5

// Timing
`define SAP_CLK_HZ 50000000
`define SAP_CORE_RATE_HZ 48000
`define SAP_BITS_PER_FRAME 64
`define SAP_HYST_HZ 1000
`define SAP_CORE_TICK (`SAP_CLK_HZ / `SAP_CORE_RATE_HZ)
`define SAP_BCLK_HALF (`SAP_CLK_HZ / (2 * `SAP_BITS_PER_FRAME * `SAP_CORE_RATE_HZ))

`endif

/* pkg/sap_pkg.sv */
`include "sap_cfg.svh"

package sap_pkg;

    typedef enum logic [1:0] {
        SAP_SRC_SERIAL,
        SAP_SRC_SPDIF,
        SAP_SRC_ACLINK
    } sap_src_t;

    typedef logic [2:0] sap_fmt_t;

    function automatic logic [5:0] sap_slots(input sap_fmt_t m);
        return m[2] ? `SAP_SLOTS_SHORT : `SAP_SLOTS_LONG;
    endfunction

    function automatic logic [5:0] sap_width(input sap_fmt_t m);
        return (m[1:0] == 2'h2) ? `SAP_WIDTH_SHORT : `SAP_WIDTH_LONG;
    endfunction

    function automatic logic sap_right(input sap_fmt_t m);
        return m[1];
    endfunction

    function automatic logic [5:0] sap_delay(input sap_fmt_t m);
        return (m == 3'h1) ? 6'h01 : 6'h00;
    endfunction

    // Offset of the first data bit inside a half frame
    function automatic logic [5:0] sap_first(input sap_fmt_t m);
        return sap_right(m) ? (sap_slots(m) - sap_width(m)) : sap_delay(m);
    endfunction

    // Short frames are slave only; the reserved code is never valid
    function automatic logic sap_fmt_ok(input sap_fmt_t m, input logic master);
        return (m != `SAP_MODE_RESERVED) && !(m[2] && master);
    endfunction

endpackage

/* rtl/sap_top.sv */
module sap_top
    import sap_pkg::*;
#(
    parameter int IN_LINES = 2,
    parameter int SRC_THR_HZ = 40000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic in_bit_clock,
    output logic in_bit_clock_o,
    output logic in_bit_clock_oe_n,
    input wire logic in_word_clock,
    output logic in_word_clock_o,
    output logic in_word_clock_oe_n,
    input wire logic [IN_LINES-1:0] in_serial_data,
    input wire logic out_bit_clock_i,
    output logic out_bit_clock,
    output logic out_bit_clock_oe_n,
    input wire logic out_word_clock_i,
    output logic out_word_clock,
    output logic out_word_clock_oe_n,
    output logic out_serial_data,
    input wire logic [47:0] tx_data,
    output logic tx_take,
    input wire logic [23:0] spdif_left,
    input wire logic [23:0] spdif_right,
    input wire logic spdif_valid,
    output logic spdif_analog_mode,
    input wire logic ac_link_mode_pin,
    input wire logic [95:0] ac_link_data,
    input wire logic ac_link_valid,
    output logic [95:0] core_data,
    output logic core_valid
);
    import sap_pkg::*;

    localparam int CH = 2 * IN_LINES;
    localparam logic [15:0] PER_SLOW = 16'(`SAP_CLK_HZ / (SRC_THR_HZ - `SAP_HYST_HZ));
    localparam logic [15:0] PER_FAST = 16'(`SAP_CLK_HZ / (SRC_THR_HZ + `SAP_HYST_HZ));
    localparam logic [10:0] TICK_LAST = 11'(`SAP_CORE_TICK - 1);
    localparam logic [3:0] BCLK_LAST = 4'(`SAP_BCLK_HALF - 1);

    // ---------------- Register file ----------------
    logic [31:0] cfg_first_q, cfg_second_q;
    logic [15:0] period_q;
    logic fir_q;
    sap_src_t src;
    logic ac_s1_q, ac_s2_q;

    wire wr_en = psel & penable & pwrite;
    wire hit_first = paddr == `SAP_OFF_CFG_FIRST;
    wire hit_second = paddr == `SAP_OFF_CFG_SECOND;
    wire hit_status = paddr == `SAP_OFF_STATUS;
    wire hit_period = paddr == `SAP_OFF_PERIOD;
    wire hit_any = hit_first | hit_second | hit_status | hit_period;

    wire sap_fmt_t in_fmt = cfg_second_q[`SAP_F_IN_FMT_LO +: 3];
    wire sap_fmt_t out_fmt = cfg_second_q[`SAP_F_OUT_FMT_LO +: 3];
    wire in_bpol = cfg_second_q[`SAP_F_IN_BCLK_POL];
    wire in_wpol = cfg_second_q[`SAP_F_IN_WCLK_POL];
    wire in_master = cfg_second_q[`SAP_F_IN_MASTER];
    wire out_bpol = cfg_second_q[`SAP_F_OUT_BCLK_POL];
    wire out_wpol = cfg_second_q[`SAP_F_OUT_WCLK_POL];
    wire out_master = ~cfg_second_q[`SAP_F_OUT_SLAVE];
    wire in_ok = sap_fmt_ok(in_fmt, in_master);
    wire out_ok = sap_fmt_ok(out_fmt, out_master);
    // Skip honoured only for the serial input as master
    wire bypass = (src == SAP_SRC_SERIAL) & in_master & cfg_first_q[`SAP_F_SKIP];

    wire [31:0] status_word = 32'(fir_q) << `SAP_F_FIR_ON
                            | 32'(bypass) << `SAP_F_BYPASS
                            | 32'(!in_ok) << `SAP_F_IN_FMT_ERR
                            | 32'(!out_ok) << `SAP_F_OUT_FMT_ERR
                            | 32'(src) << `SAP_F_SRC_LO
                            | 32'(ac_s2_q) << `SAP_F_AC_PIN;

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit_any;
    assign prdata = !(psel & penable & ~pwrite) ? 32'h0000_0000 :
                    hit_first ? cfg_first_q :
                    hit_second ? cfg_second_q :
                    hit_status ? status_word :
                    hit_period ? {16'h0000, period_q} : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_first_q <= `SAP_RST_CFG_FIRST;
            cfg_second_q <= `SAP_RST_CFG_SECOND;
        end else begin
            if (wr_en && hit_first) cfg_first_q <= pwdata & 32'h0000_0007;
            if (wr_en && hit_second) cfg_second_q <= pwdata & 32'h0000_3F3F;
        end
    end

    assign spdif_analog_mode = cfg_first_q[`SAP_F_SPDIF_ANALOG];

    // ---------------- Receive side, in the input bit-clock domain ----------------
    // Polarity 0 samples on the falling pin edge by inverting the clock
    wire rx_clk = in_bit_clock ^ ~in_bpol;
    logic [3:0] rx_fmt_s1_q, rx_fmt_s2_q;
    logic rx_wc_q, rx_tgl_q;
    logic [5:0] rx_cnt_q;
    logic [23:0] rx_sh_q [IN_LINES];
    logic [23:0] rx_word_q [CH];
    logic [23:0] rx_hold_q [CH];

    // Format is quasi-static: software changes it only with the port idle
    wire sap_fmt_t rx_fmt = rx_fmt_s2_q[2:0];
    wire rx_ok = rx_fmt_s2_q[3];
    wire rx_wc = in_word_clock ^ in_wpol;
    wire rx_first = rx_wc != rx_wc_q;
    wire [5:0] rx_idx = rx_first ? 6'h00 : rx_cnt_q;
    wire [5:0] rx_last = sap_right(rx_fmt) ? sap_slots(rx_fmt) - 6'h01 :
                         sap_delay(rx_fmt) + sap_width(rx_fmt) - 6'h01;
    wire rx_latch = rx_ok & (rx_idx == rx_last);
    wire rx_short = sap_width(rx_fmt) == `SAP_WIDTH_SHORT;

    function automatic logic [23:0] rx_just(input logic [23:0] sh, input logic bit_in,
                                            input logic short_w);
        logic [23:0] w;
        w = {sh[22:0], bit_in};
        return short_w ? {w[15:0], 8'h00} : w;
    endfunction

    always_ff @(posedge rx_clk or negedge presetn) begin
        if (!presetn) begin
            rx_fmt_s1_q <= 4'h0;
            rx_fmt_s2_q <= 4'h0;
            rx_wc_q <= 1'b0;
            rx_cnt_q <= 6'h00;
            rx_tgl_q <= 1'b0;
        end else begin
            rx_fmt_s1_q <= {in_ok, in_fmt};
            rx_fmt_s2_q <= rx_fmt_s1_q;
            rx_wc_q <= rx_wc;
            rx_cnt_q <= (rx_idx == 6'h3F) ? rx_idx : rx_idx + 6'h01;
            if (rx_latch && rx_wc) rx_tgl_q <= ~rx_tgl_q;
        end
    end

    // Word low is the left channel, high the right one
    for (genvar l = 0; l < IN_LINES; l++) begin : g_rx
        always_ff @(posedge rx_clk or negedge presetn) begin
            if (!presetn) begin
                rx_sh_q[l] <= 24'h000000;
                rx_word_q[2*l] <= 24'h000000;
                rx_word_q[2*l+1] <= 24'h000000;
                rx_hold_q[2*l] <= 24'h000000;
                rx_hold_q[2*l+1] <= 24'h000000;
            end else begin
                rx_sh_q[l] <= {rx_sh_q[l][22:0], in_serial_data[l]};
                if (rx_latch && !rx_wc) begin
                    rx_word_q[2*l] <= rx_just(rx_sh_q[l], in_serial_data[l], rx_short);
                end
                if (rx_latch && rx_wc) begin
                    rx_word_q[2*l+1] <= rx_just(rx_sh_q[l], in_serial_data[l], rx_short);
                    rx_hold_q[2*l] <= rx_word_q[2*l];
                    rx_hold_q[2*l+1] <= rx_just(rx_sh_q[l], in_serial_data[l], rx_short);
                end
            end
        end
    end

    // Frame crosses by toggle; the hold words stay put for a whole frame
    logic rx_t1_q, rx_t2_q, rx_t3_q;
    logic [95:0] ser_frame_q;
    logic ser_new_q;
    wire rx_event = rx_t2_q ^ rx_t3_q;
    logic [95:0] ser_flat;

    always_comb begin
        ser_flat = 96'h0;
        for (int c = 0; c < CH && c < 4; c++) begin
            ser_flat[c*24 +: 24] = rx_hold_q[c];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_t1_q <= 1'b0;
            rx_t2_q <= 1'b0;
            rx_t3_q <= 1'b0;
            ser_frame_q <= 96'h0;
            ser_new_q <= 1'b0;
        end else begin
            rx_t1_q <= rx_tgl_q;
            rx_t2_q <= rx_t1_q;
            rx_t3_q <= rx_t2_q;
            ser_new_q <= rx_event & in_ok;
            if (rx_event) ser_frame_q <= ser_flat;
        end
    end

    // ---------------- Source selection and resampling ----------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ac_s1_q <= 1'b0;
            ac_s2_q <= 1'b0;
        end else begin
            ac_s1_q <= ac_link_mode_pin;
            ac_s2_q <= ac_s1_q;
        end
    end

    assign src = ac_s2_q ? SAP_SRC_ACLINK :
                 cfg_first_q[`SAP_F_SRC_SEL] ? SAP_SRC_SPDIF : SAP_SRC_SERIAL;

    wire src_new = (src == SAP_SRC_SERIAL) ? ser_new_q :
                   (src == SAP_SRC_SPDIF) ? spdif_valid : ac_link_valid;
    wire [95:0] src_data = (src == SAP_SRC_SERIAL) ? ser_frame_q :
                           (src == SAP_SRC_SPDIF) ? {48'h0, spdif_right, spdif_left} :
                           ac_link_data;

    logic [95:0] src_hold_q;
    logic [15:0] per_cnt_q;
    logic [10:0] tick_q;
    wire tick = tick_q == TICK_LAST;

    // Zero-order hold resampler: the latest input sample is re-issued on the
    // fixed core tick; the filter stage choice is reported for the DSP path.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_hold_q <= 96'h0;
            per_cnt_q <= 16'h0000;
            period_q <= 16'h0000;
            fir_q <= 1'b0;
            tick_q <= 11'h000;
            core_data <= 96'h0;
            core_valid <= 1'b0;
        end else begin
            tick_q <= tick ? 11'h000 : tick_q + 11'h001;
            if (src_new) begin
                src_hold_q <= src_data;
                per_cnt_q <= 16'h0001;
                period_q <= per_cnt_q;
            end else if (per_cnt_q != 16'hFFFF) begin
                per_cnt_q <= per_cnt_q + 16'h0001;
            end
            if (period_q > PER_SLOW) fir_q <= 1'b1;
            else if (period_q < PER_FAST) fir_q <= 1'b0;
            core_valid <= bypass ? src_new : tick;
            if (bypass && src_new) core_data <= src_data;
            else if (!bypass && tick) core_data <= src_hold_q;
        end
    end

    // ---------------- Master clock generator (64 bits per 48 kHz frame) ----------------
    logic [3:0] gen_div_q;
    logic gen_bclk_q;
    logic [5:0] gen_idx_q;
    logic in_wc_q, out_wc_q;
    wire gen_wrap = gen_div_q == BCLK_LAST;
    wire gen_fall = gen_wrap & gen_bclk_q;
    wire [5:0] gen_idx_nx = gen_idx_q + 6'h01;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gen_div_q <= 4'h0;
            gen_bclk_q <= 1'b0;
            gen_idx_q <= 6'h3F;
            in_wc_q <= 1'b0;
            out_wc_q <= 1'b0;
        end else begin
            gen_div_q <= gen_wrap ? 4'h0 : gen_div_q + 4'h1;
            if (gen_wrap) gen_bclk_q <= ~gen_bclk_q;
            if (gen_fall) begin
                gen_idx_q <= gen_idx_nx;
                in_wc_q <= gen_idx_nx[5] ^ in_wpol;
                out_wc_q <= gen_idx_nx[5] ^ out_wpol;
            end
        end
    end

    assign in_bit_clock_o = gen_bclk_q ^ ~in_bpol;
    assign in_bit_clock_oe_n = ~in_master;
    assign in_word_clock_o = in_wc_q;
    assign in_word_clock_oe_n = ~in_master;
    assign out_bit_clock = gen_bclk_q ^ ~out_bpol;
    assign out_bit_clock_oe_n = ~out_master;
    assign out_word_clock = out_wc_q;
    assign out_word_clock_oe_n = ~out_master;

    // ---------------- Transmit side ----------------
    logic ob_s1_q, ob_s2_q, ob_s3_q, ow_s1_q, ow_s2_q;
    logic tx_wc_q, tx_half_q, tx_ser_q, tx_take_q;
    logic [5:0] tx_idx_q;
    logic [47:0] tx_word_q;

    wire ob_now = ob_s2_q ^ ~out_bpol;
    wire ob_old = ob_s3_q ^ ~out_bpol;
    wire sl_launch = ob_old & ~ob_now;
    wire sl_sample = ~ob_old & ob_now;
    wire tx_launch = out_master ? gen_fall : sl_launch;
    wire tx_half = out_master ? gen_idx_nx[5] : tx_wc_q;
    wire tx_new = tx_half != tx_half_q;
    wire [5:0] tx_idx = tx_new ? 6'h00 : tx_idx_q + 6'h01;
    wire [5:0] tx_off = sap_first(out_fmt);
    wire [5:0] tx_rel = tx_idx - tx_off;
    wire tx_in_win = (tx_idx >= tx_off) & (tx_rel < sap_width(out_fmt));
    wire [23:0] tx_cur = tx_half ? tx_word_q[47:24] : tx_word_q[23:0];
    wire tx_bit = out_ok & tx_in_win & tx_cur[5'd23 - tx_rel[4:0]];
    wire tx_load = tx_launch & tx_new & ~tx_half;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ob_s1_q <= 1'b0;
            ob_s2_q <= 1'b0;
            ob_s3_q <= 1'b0;
            ow_s1_q <= 1'b0;
            ow_s2_q <= 1'b0;
            tx_wc_q <= 1'b0;
            tx_half_q <= 1'b1;
            tx_idx_q <= 6'h00;
            tx_word_q <= 48'h0;
            tx_ser_q <= 1'b0;
            tx_take_q <= 1'b0;
        end else begin
            ob_s1_q <= out_bit_clock_i;
            ob_s2_q <= ob_s1_q;
            ob_s3_q <= ob_s2_q;
            ow_s1_q <= out_word_clock_i;
            ow_s2_q <= ow_s1_q;
            if (sl_sample) tx_wc_q <= ow_s2_q ^ out_wpol;
            tx_take_q <= tx_load;
            if (tx_launch) begin
                tx_half_q <= tx_half;
                tx_idx_q <= tx_idx;
                tx_ser_q <= tx_load ? (out_ok & (tx_off == 6'h00) & tx_data[23]) : tx_bit;
            end
            if (tx_load) tx_word_q <= tx_data;
        end
    end

    assign out_serial_data = tx_ser_q;
    assign tx_take = tx_take_q;

endmodule

/* dv/sap_top_sva.sv */
`include "sap_cfg.svh"

module sap_top_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic out_bit_clock,
    input wire logic out_bit_clock_oe_n,
    input wire logic out_word_clock,
    input wire logic out_serial_data,
    input wire logic tx_take,
    input wire logic spdif_analog_mode,
    input wire logic core_valid
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    wire logic acc_w = psel && penable;
    wire logic wr_first = acc_w && pwrite && paddr == `SAP_OFF_CFG_FIRST;
    wire logic mst_w = !out_bit_clock_oe_n;

    slverr_access_a: assert property (pslverr |-> acc_w && pready)
        else $error("slave error outside an access phase");
    rdata_idle_a: assert property (!(acc_w && !pwrite) |-> prdata == 32'h0)
        else $error("read data outside a read access");
    analog_load_a: assert property (wr_first |=> spdif_analog_mode == $past(pwdata[2]))
        else $error("receiver mode not loaded");
    analog_hold_a: assert property (!wr_first |=> $stable(spdif_analog_mode))
        else $error("receiver mode changed without a write");
    core_pulse_a: assert property (core_valid |=> !core_valid)
        else $error("core strobe longer than one cycle");
    take_pulse_a: assert property (tx_take |=> !tx_take [*8])
        else $error("transmit take too close");
    bclk_half_a: assert property (mst_w && $rose(out_bit_clock) |->
        out_bit_clock [*8] ##1 !out_bit_clock)
        else $error("bit clock half period wrong");
    data_launch_a: assert property (mst_w && $changed(out_serial_data) |-> !out_bit_clock)
        else $error("serial data moved while bit clock high");
    wclk_launch_a: assert property (mst_w && $changed(out_word_clock) |-> !out_bit_clock)
        else $error("word clock moved while bit clock high");
endmodule

bind sap_top sap_top_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .out_bit_clock, .out_bit_clock_oe_n,
    .out_word_clock, .out_serial_data, .tx_take, .spdif_analog_mode, .core_valid);

/* dv/sap_link_model.sv */
module sap_link_model (
    input wire logic rst_n,
    output logic bclk,
    output logic wclk,
    output logic [1:0] sd
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        bclk = 1'b1;
        wclk = 1'b0;
        sd = 2'b00;
        #3;
        // Edges during reset let the receive domain clear
        while (!rst_n) begin
            #6 bclk = ~bclk;
        end
        bclk = 1'b1;
    end

    // Clock stands still between bursts; three identical frames per burst
    task automatic send(input logic dly, input logic [23:0] w [4]);
        int k;
        repeat (3) begin
            for (int h = 0; h < 2; h++) begin
                for (int i = 0; i < 32; i++) begin
                    k = i - int'(dly);
                    #6 bclk = 1'b0;
                    wclk = h[0];
                    for (int l = 0; l < 2; l++) begin
                        sd[l] = (k >= 0 && k < 24) ? w[2 * l + h][23 - k] : 1'b0;
                    end
                    #6 bclk = 1'b1;
                end
            end
        end
        #6 bclk = 1'b0;
        wclk = 1'b0;
        sd = ~sd;
        #6 bclk = 1'b1;
    endtask
endmodule

/* dv/test_serial_audio_ports_input_select.sv */
`include "sap_cfg.svh"

module test_serial_audio_ports_input_select;
    timeunit 1ns;
    timeprecision 100ps;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic m_bclk, m_wclk, ibc_o, ibc_oe_n, iwc_o, iwc_oe_n, obc_oe_n;
    logic obc, owc, osd, owc_q, tx_on;
    logic [30:0] tx_sh;
    logic [23:0] tx_exp;
    logic [1:0] m_sd;
    logic [47:0] tx_data;
    logic tx_take, ana, aclp, acv, spv, cv;
    logic [23:0] spl, spr;
    logic [95:0] acd, core_data;
    int errors, checks_done, seed;

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    sap_link_model m_u (.rst_n(presetn), .bclk(m_bclk), .wclk(m_wclk), .sd(m_sd));

    sap_top dut_u (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .in_bit_clock(ibc_oe_n ? m_bclk : ibc_o), .in_bit_clock_o(ibc_o),
        .in_bit_clock_oe_n(ibc_oe_n), .in_word_clock(iwc_oe_n ? m_wclk : iwc_o),
        .in_word_clock_o(iwc_o), .in_word_clock_oe_n(iwc_oe_n), .in_serial_data(m_sd),
        .out_bit_clock_i(1'b0), .out_bit_clock(obc), .out_bit_clock_oe_n(obc_oe_n),
        .out_word_clock_i(1'b0), .out_word_clock(owc), .out_word_clock_oe_n(),
        .out_serial_data(osd), .tx_data, .tx_take, .spdif_left(spl), .spdif_right(spr),
        .spdif_valid(spv), .spdif_analog_mode(ana), .ac_link_mode_pin(aclp),
        .ac_link_data(acd), .ac_link_valid(acv), .core_data, .core_valid(cv)
    );

    // The word just loaded is the one the left half now starting must carry
    always @(posedge pclk) begin
        if (tx_take === 1'b1) begin
            tx_exp <= tx_data[23:0];
            tx_data <= 48'({$random(seed), $random(seed)});
        end
    end

    // Mode 1 receiver: left word sits at bit indices 1..24 of the low half
    always @(posedge obc) begin
        tx_sh <= {tx_sh[29:0], osd};
        owc_q <= owc;
        if (tx_on && owc && !owc_q) chk(tx_sh[30:7], tx_exp);
    end

    task automatic finish_test;
        $display("Checks %0d, errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [95:0] g, input logic [95:0] x);
        checks_done++;
        if (g !== x) begin
            errors++;
            $display("Error at %0t: got %0h expected %0h", $time, g, x);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) errors++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(r & m, x & m);
    endtask

    task automatic wait_cv(output int n);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (cv !== 1'b1 && n < 3000);
        if (n >= 3000) errors++;
    endtask

    task automatic spd(input int gap, input logic [23:0] lv, input logic [23:0] rv);
        repeat (4) begin
            spl <= lv;
            spr <= rv;
            spv <= 1'b1;
            @(posedge pclk);
            spv <= 1'b0;
            repeat (gap - 1) @(posedge pclk);
        end
    endtask

    // Short frames are slave only; code 5 is never a frame
    function automatic logic fmt_bad(input int m, input logic mst);
        return m == 5 || (m >= 4 && mst);
    endfunction

    initial begin
        #1_500_000;
        errors++;
        finish_test;
    end

    initial begin
        logic [23:0] w [4];
        logic [95:0] ad;
        logic [31:0] v;
        int n;
        seed = 32'hEC67;
        errors = 0;
        tx_on = 1'b0;
        checks_done = 0;
        {presetn, psel, penable, pwrite, spv, aclp, acv} = 7'h00;
        {paddr, pwdata, tx_data, spl, spr, acd} = '0;
        repeat (3) @(posedge pclk);
        chk({ibc_oe_n, obc_oe_n}, 2'b10);
        presetn <= 1'b1;
        rd(`SAP_OFF_CFG_FIRST, 32'hFFFF_FFFF, 32'h0);
        rd(`SAP_OFF_CFG_SECOND, 32'hFFFF_FFFF, 32'h0909);
        apb(1'b1, 8'h10, 32'hFFFF_FFFF);
        chk(e, 1'b1);
        rd(8'h10, 32'hFFFF_FFFF, 32'h0);
        chk(e, 1'b1);
        rd(`SAP_OFF_CFG_SECOND, 32'hFFFF_FFFF, 32'h0909);
        for (int m = 0; m < 8; m++) begin
            v = 32'h0808 | 32'(m << 8) | 32'(m);
            apb(1'b1, `SAP_OFF_CFG_SECOND, v);
            rd(`SAP_OFF_CFG_SECOND, 32'hFFFF_FFFF, v);
            rd(`SAP_OFF_STATUS, 32'hC, 32'({fmt_bad(m, 1'b1), fmt_bad(m, 1'b0), 2'b0}));
        end
        for (int d = 1; d >= 0; d--) begin
            apb(1'b1, `SAP_OFF_CFG_SECOND, 32'h0908 | 32'(d));
            foreach (w[i]) w[i] = 24'($random(seed));
            m_u.send(d[0], w);
            wait_cv(n);
            wait_cv(n);
            chk(core_data, {w[3], w[2], w[1], w[0]});
            chk(n == 1041 || n == 1042, 1'b1);
        end
        apb(1'b1, `SAP_OFF_CFG_SECOND, 32'h0929);
        apb(1'b1, `SAP_OFF_CFG_FIRST, 32'h1);
        rd(`SAP_OFF_STATUS, 32'h72, 32'h02);
        chk(ibc_oe_n, 1'b0);
        apb(1'b1, `SAP_OFF_CFG_SECOND, 32'h0909);
        rd(`SAP_OFF_STATUS, 32'h72, 32'h0);
        apb(1'b1, `SAP_OFF_CFG_FIRST, 32'h7);
        rd(`SAP_OFF_STATUS, 32'h72, 32'h10);
        chk(ana, 1'b1);
        v = $random(seed);
        spd(1500, v[23:0], v[31:8]);
        rd(`SAP_OFF_PERIOD, 32'hFFFF, 32'd1500);
        rd(`SAP_OFF_STATUS, 32'h1, 32'h1);
        wait_cv(n);
        chk(core_data[47:0], {v[31:8], v[23:0]});
        spd(1250, v[31:8], v[23:0]);
        rd(`SAP_OFF_STATUS, 32'h1, 32'h1);
        spd(600, v[31:8], v[23:0]);
        rd(`SAP_OFF_STATUS, 32'h1, 32'h0);
        spd(1250, v[31:8], v[23:0]);
        rd(`SAP_OFF_STATUS, 32'h1, 32'h0);
        apb(1'b1, `SAP_OFF_CFG_FIRST, 32'h2);
        @(posedge pclk);
        chk(ana, 1'b0);
        n = 0;
        tx_on = 1'b1;
        repeat (2048) begin
            @(posedge pclk);
            if (tx_take === 1'b1) n++;
        end
        tx_on = 1'b0;
        chk(n, 2);
        aclp <= 1'b1;
        repeat (4) @(posedge pclk);
        rd(`SAP_OFF_STATUS, 32'h70, 32'h60);
        ad = {$random(seed), $random(seed), $random(seed)};
        acd <= ad;
        acv <= 1'b1;
        @(posedge pclk);
        acv <= 1'b0;
        wait_cv(n);
        wait_cv(n);
        chk(core_data, ad);
        finish_test;
    end
endmodule
